// file: design/slc_pkg.sv
package slc_pkg;

	// master clock figures
	localparam int CLK_PERIOD_NS = 50;

	// default strobe timing, in clock cycles
	localparam logic [1:0] SETUP_COUNT = 2'h1;
	localparam logic [1:0] STROBE_COUNT = 2'h3;
	localparam logic [1:0] HOLD_COUNT = 2'h2;
	localparam logic [1:0] TIMER_RESET = 2'h0;

	// cycle space, io or memory
	typedef enum logic {SLC_SPACE_IO, SLC_SPACE_MEM} slc_space_t;

	// request from the main sequencer
	typedef struct packed {
		slc_space_t space;
		logic write;
	} slc_req_t;

	// active low strobe set driven to the bus
	typedef struct packed {
		logic io_rd_n;
		logic io_wr_n;
		logic mem_rd_n;
		logic mem_wr_n;
	} slc_strobe_t;

	localparam slc_strobe_t STROBE_IDLE = 4'hF;

endpackage

// file: design/slc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module slc_sync
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// asynchronous level and its synchronised copy
	input wire logic async_i,
	output logic sync_o
);

	logic stage1_reg;
	logic stage2_reg;

	// two flops; stage1 feeds only stage2, resets to idle-high pulled-up level
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			stage1_reg <= 1'b1;
			stage2_reg <= 1'b1;
		end
		else
		begin
			stage1_reg <= async_i;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_o = stage2_reg;

endmodule
`default_nettype wire

// file: design/slc_strobe_ctl.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - with neither line driven the cycle keeps its fixed default timing
// - while synchronised ready is low the active strobe stays asserted
// - after ready returns the cycle ends with the normal ending sequence
// - ready and zero-wait pass synchronisers before the sequencer uses them
// - memory cycles stretch through ready just like io cycles
// - synchronised zero-wait ends the active strobe at the earliest state
// - zero-wait latency through the synchroniser is fixed at two clocks
// - zero-wait with the strobe's first cycle gives the shortest cycle
// - memory cycles shorten through zero-wait just like io cycles
// - one shared 2-bit wait timer wraps 3 to 0 and can be cleared
// - on reads and writes alike the data latch opens for the last strobe clock and closes as the strobe ends
// - acknowledge follows strobe end plus an address hold delay
// - memory cycles use memory strobes instead of io strobes
module slc_strobe_ctl
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_I,
	// main sequencer handshake
	input wire logic DO_CYCLE_I,
	input wire slc_pkg::slc_req_t REQ_I,
	output logic CYCLE_ACK_O,
	// expansion bus length control pins, active low
	input wire logic READY_I,
	input wire logic ZERO_WAIT_N_I,
	// expansion bus strobes and read latch, active low
	output slc_pkg::slc_strobe_t STROBE_O,
	output logic LATCH_OPEN_N_O
);

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_LATCH, ST_HOLD, ST_ACK} slc_state_t;

	slc_state_t state_reg;
	slc_state_t state_next;
	logic [1:0] timer_reg;
	logic [1:0] timer_next;
	slc_pkg::slc_req_t req_reg;
	slc_pkg::slc_strobe_t strobe_reg;
	slc_pkg::slc_strobe_t strobe_next;
	logic latch_n_reg;
	logic latch_n_next;
	logic ack_reg;
	logic ready_sync;
	logic zws_n_sync;

	// synchronisers for the two open-collector lines
	slc_sync u_sync_ready
	(
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.async_i(READY_I),
		.sync_o(ready_sync)
	);

	slc_sync u_sync_zws
	(
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.async_i(ZERO_WAIT_N_I),
		.sync_o(zws_n_sync)
	);

	// length control decisions, same for io and memory space
	wire stretch = !ready_sync;
	wire shorten = !zws_n_sync && !stretch;
	wire timer_done = (timer_reg == slc_pkg::STROBE_COUNT);
	wire end_strobe = !stretch && (shorten || timer_done);
	wire strobe_on = (state_next == ST_STROBE) || (state_next == ST_LATCH);

	// strobe selection by space and direction
	always_comb
	begin
		strobe_next = slc_pkg::STROBE_IDLE;
		if (strobe_on)
		begin
			if (req_reg.space == slc_pkg::SLC_SPACE_MEM)
			begin
				strobe_next.mem_rd_n = req_reg.write;
				strobe_next.mem_wr_n = !req_reg.write;
			end
			else
			begin
				strobe_next.io_rd_n = req_reg.write;
				strobe_next.io_wr_n = !req_reg.write;
			end
		end
	end

	// sequencer next state and shared timer
	always_comb
	begin
		state_next = state_reg;
		timer_next = timer_reg + 2'h1;
		latch_n_next = 1'b1;
		case (state_reg)
			ST_IDLE:
			begin
				timer_next = slc_pkg::TIMER_RESET;
				if (DO_CYCLE_I)
					state_next = ST_SETUP;
			end
			ST_SETUP:
			begin
				if (timer_reg == slc_pkg::SETUP_COUNT)
				begin
					state_next = ST_STROBE;
					timer_next = slc_pkg::TIMER_RESET;
				end
			end
			ST_STROBE:
			begin
				if (stretch)
					timer_next = timer_reg;
				if (end_strobe)
				begin
					state_next = ST_LATCH;
					latch_n_next = 1'b0;
				end
			end
			ST_LATCH:
			begin
				state_next = ST_HOLD;
				timer_next = slc_pkg::TIMER_RESET;
			end
			ST_HOLD:
			begin
				if (timer_reg == slc_pkg::HOLD_COUNT)
					state_next = ST_ACK;
			end
			ST_ACK:
			begin
				timer_next = slc_pkg::TIMER_RESET;
				if (!DO_CYCLE_I)
					state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state and output flops
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			state_reg <= ST_IDLE;
			timer_reg <= slc_pkg::TIMER_RESET;
			req_reg <= '0;
			strobe_reg <= slc_pkg::STROBE_IDLE;
			latch_n_reg <= 1'b1;
			ack_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			if (state_reg == ST_IDLE && DO_CYCLE_I)
				req_reg <= REQ_I;
			strobe_reg <= strobe_next;
			latch_n_reg <= latch_n_next;
			ack_reg <= (state_next == ST_ACK);
		end
	end

	assign STROBE_O = strobe_reg;
	assign LATCH_OPEN_N_O = latch_n_reg;
	assign CYCLE_ACK_O = ack_reg;

	// strobe stays on while stretched
	property p_stretch_hold;
		@(posedge CLK_I) disable iff (RESET_I)
		(state_reg == ST_STROBE && stretch) |=> (state_reg == ST_STROBE);
	endproperty
	a_stretch_hold: assert property (p_stretch_hold) else $error("strobe ended while stretched");

	// shorten moves off the strobe at once
	property p_shorten;
		@(posedge CLK_I) disable iff (RESET_I)
		(state_reg == ST_STROBE && !zws_n_sync && ready_sync) |=> (state_reg == ST_LATCH);
	endproperty
	a_shorten: assert property (p_shorten) else $error("zero-wait did not end strobe");

	// stretch beats shorten
	property p_priority;
		@(posedge CLK_I) disable iff (RESET_I)
		(state_reg == ST_STROBE && !ready_sync && !zws_n_sync) |=> (state_reg != ST_LATCH);
	endproperty
	a_priority: assert property (p_priority) else $error("shorten beat stretch");

	// default strobe length when lines idle
	property p_default;
		@(posedge CLK_I) disable iff (RESET_I)
		$rose(state_reg == ST_STROBE) && ready_sync && zws_n_sync ##1 (ready_sync && zws_n_sync) [*3]
		|=> (state_reg == ST_LATCH);
	endproperty
	a_default: assert property (p_default) else $error("default strobe length wrong");

	// latch open for the last strobe clock, closing as strobe ends on reads and writes alike
	property p_latch;
		@(posedge CLK_I) disable iff (RESET_I)
		!latch_n_reg |-> (state_reg == ST_LATCH && strobe_reg != slc_pkg::STROBE_IDLE)
			##1 (strobe_reg == slc_pkg::STROBE_IDLE);
	endproperty
	a_latch: assert property (p_latch) else $error("latch and strobe out of order");

	// ack follows hold delay after strobe
	property p_ack;
		@(posedge CLK_I) disable iff (RESET_I)
		(state_reg == ST_LATCH) |-> ##4 CYCLE_ACK_O;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not after hold delay");

	// ack never while a strobe is active
	property p_ack_idle;
		@(posedge CLK_I) disable iff (RESET_I)
		CYCLE_ACK_O |-> (STROBE_O == slc_pkg::STROBE_IDLE);
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack during strobe");

	// memory cycles never drive io strobes
	property p_space;
		@(posedge CLK_I) disable iff (RESET_I)
		(req_reg.space == slc_pkg::SLC_SPACE_MEM && state_reg != ST_IDLE)
		|-> (STROBE_O.io_rd_n && STROBE_O.io_wr_n);
	endproperty
	a_space: assert property (p_space) else $error("io strobe in memory cycle");

	// timer wraps 3 to 0 as an unstretched strobe runs out
	property p_wrap;
		@(posedge CLK_I) disable iff (RESET_I)
		(timer_reg == 2'h3 && state_reg == ST_STROBE && ready_sync) |=> (timer_reg == 2'h0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("timer did not wrap");

endmodule
`default_nettype wire

// file: sim/slc_peripheral_model.sv
`timescale 1ns/100ps
`default_nettype none
module slc_peripheral_model
(
	// clock and watched strobes
	input wire logic clk_i,
	input wire slc_pkg::slc_strobe_t strobe_i,
	// behaviour chosen by the bench
	input wire logic [3:0] stretch_i,
	input wire logic shorten_i,
	// open-collector length lines, released means pulled high
	output logic ready_o,
	output logic zero_wait_n_o
);
	logic [3:0] held_reg;
	logic active;
	// a strobe is active when any bit is low
	assign active = (strobe_i != slc_pkg::STROBE_IDLE);
	initial
	begin
		ready_o = 1'b1;
		zero_wait_n_o = 1'b1;
		held_reg = 4'h0;
	end
	// pins move on the falling edge, away from the sampling edge
	always @(negedge clk_i)
	begin
		held_reg <= active ? held_reg + 4'h1 : 4'h0;
		ready_o <= !(active && held_reg < stretch_i);
		zero_wait_n_o <= !(active && shorten_i);
	end
endmodule
`default_nettype wire

// file: sim/test_isa_strobe_length_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_isa_strobe_length_control;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic do_cycle = 1'b0;
	slc_pkg::slc_req_t req = '0;
	logic [3:0] stretch = 4'h0;
	logic shorten = 1'b0;
	logic ready;
	logic zero_wait_n;
	logic ack;
	logic latch_n;
	slc_pkg::slc_strobe_t strobe;
	int bad_count = 0;
	int checks = 0;
	int wa;
	int wb;
	int g;
	// take edge plus the setup timer run, counted in clocks up to the first strobe clock
	localparam int lead_edges = slc_pkg::SETUP_COUNT + 2;
	// timer 0 up to the strobe count, plus the latch clock
	localparam int default_width = slc_pkg::STROBE_COUNT + 2;
	// hold timer run plus the edge that raises ack
	localparam int hold_gap = slc_pkg::HOLD_COUNT + 1;
	// pin drops half a clock after the strobe, two sync flops, then the latch clock
	localparam int short_width = 4;
	// 20 MHz master clock
	always #(slc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
	slc_strobe_ctl i_dut (.CLK_I(clk), .RESET_I(reset), .DO_CYCLE_I(do_cycle), .REQ_I(req),
		.CYCLE_ACK_O(ack), .READY_I(ready), .ZERO_WAIT_N_I(zero_wait_n),
		.STROBE_O(strobe), .LATCH_OPEN_N_O(latch_n));
	slc_peripheral_model i_peri (.clk_i(clk), .strobe_i(strobe), .stretch_i(stretch),
		.shorten_i(shorten), .ready_o(ready), .zero_wait_n_o(zero_wait_n));
	task automatic compare(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one whole cycle: returns strobe width and strobe-end to ack gap
	task automatic run_cycle(input slc_pkg::slc_req_t r, output int w, output int gap);
		slc_pkg::slc_strobe_t exp;
		int n;
		int lows;
		int at;
		exp.io_rd_n = !(r.space == slc_pkg::SLC_SPACE_IO && !r.write);
		exp.io_wr_n = !(r.space == slc_pkg::SLC_SPACE_IO && r.write);
		exp.mem_rd_n = !(r.space == slc_pkg::SLC_SPACE_MEM && !r.write);
		exp.mem_wr_n = !(r.space == slc_pkg::SLC_SPACE_MEM && r.write);
		@(negedge clk);
		do_cycle = 1'b1;
		req = r;
		n = 0;
		w = 0;
		lows = 0;
		at = 0;
		gap = 0;
		while (strobe === slc_pkg::STROBE_IDLE && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		compare(n, lead_edges);
		while (strobe === exp && w < 60)
		begin
			w++;
			if (latch_n === 1'b0)
			begin
				lows++;
				at = w;
			end
			@(negedge clk);
		end
		compare(strobe, slc_pkg::STROBE_IDLE);
		compare(lows, 1);
		compare(at, w);
		while (ack !== 1'b1 && gap < 50)
		begin
			@(negedge clk);
			gap++;
		end
		compare(gap, hold_gap);
		do_cycle = 1'b0;
		@(negedge clk);
		compare(ack, 1'b0);
	endtask
	task automatic t_plain;
		for (int k = 0; k < 4; k++)
		begin
			run_cycle(k[1:0], wa, g);
			compare(wa, default_width);
		end
	endtask
	task automatic t_stretch;
		stretch = 4'h8;
		run_cycle('{slc_pkg::SLC_SPACE_IO, 1'b0}, wa, g);
		run_cycle('{slc_pkg::SLC_SPACE_MEM, 1'b1}, wb, g);
		compare(wa > 8, 1'b1);
		compare(wb, wa);
		stretch = 4'h0;
	endtask
	task automatic t_shorten;
		shorten = 1'b1;
		run_cycle('{slc_pkg::SLC_SPACE_IO, 1'b1}, wa, g);
		run_cycle('{slc_pkg::SLC_SPACE_MEM, 1'b0}, wb, g);
		compare(wa, short_width);
		compare(wa < default_width, 1'b1);
		compare(wb, wa);
		shorten = 1'b0;
	endtask
	task automatic t_both;
		stretch = 4'h6;
		shorten = 1'b1;
		run_cycle('{slc_pkg::SLC_SPACE_IO, 1'b0}, wa, g);
		compare(wa > 6, 1'b1);
		stretch = 4'h0;
		shorten = 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		reset = 1'b0;
		t_plain();
		t_stretch();
		t_shorten();
		t_both();
		tally_and_finish();
	end
	// watchdog, far beyond the roughly 140 clocks the tests need
	initial
	begin
		#(2000 * slc_pkg::CLK_PERIOD_NS);
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
